// >>> verilog/twt_pkg.sv
// Constants, opcodes and timing for the three-wire thermometer command port.
// Assumes a 200 MHz mclk; long counts are overridable at the top module.
// Operation
// R01 - Single-conversion set: start runs one conversion, then standby.
// R02 - Single-conversion clear: start runs conversions repeatedly until stopped.
// R03 - Resolution bits pick 9 to 12 bits and 93.75 to 750 ms.
// R04 - Transactions start with select high; bus ignored while select low.
// R05 - Select falling ends the transaction and floats the data line.
// R06 - Host drops select after every complete transaction.
// R07 - Commands and data shift least significant bit first.
// R08 - Written bits are sampled on the rising clock edge.
// R09 - Read bits driven on falling edge, floated after the rising edge.
// R10 - Start, stop and software reset finish at the eighth bit.
// R11 - Host sends write data right after the last command bit.
// R12 - Writes keep only the needed bits; extra bits are discarded.
// R13 - Writes commit only after 12 or 8 bits; short ones discarded.
// R14 - Read data follows the command byte, then zeros until deselect.
// R15 - Opcodes 51h start, 22h stop, 54h software reset.
// R16 - Opcodes AAh, A1h, A2h read temperature, upper and lower limits.
// R17 - Opcode ACh reads and 0Ch writes the configuration byte.
// R18 - Opcodes 01h and 02h write upper and lower limits.
// R19 - Stop command halts repeating conversions in continuous mode.
// R20 - Software reset stops conversion and restores power-up state; code keeps limits and resolution, host-control and single bits.
// R21 - Temperature read returns the last completed conversion.
// R22 - Host waits 10 ms after a write before the next write.
// R23 - Host-control bit set disables stand-alone; clear enables it deselected.
// R24 - Stand-alone: convert held low repeats; pulse under 10 ms converts once.
// R25 - Bits counted from select rise; first eight form the command.
package twt_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CONV_TIME_9B_US = 93750;
    localparam int CONV_TIME_10B_US = 187500;
    localparam int CONV_TIME_11B_US = 375000;
    localparam int CONV_TIME_12B_US = 750000;
    localparam int SA_PULSE_TIME_US = 10000;
    localparam int NV_WRITE_TIME_US = 10000;
    localparam int CONV_CYC_9B = CONV_TIME_9B_US * 1000 / CLK_PERIOD_NS;
    localparam int CONV_CYC_10B = CONV_TIME_10B_US * 1000 / CLK_PERIOD_NS;
    localparam int CONV_CYC_11B = CONV_TIME_11B_US * 1000 / CLK_PERIOD_NS;
    localparam int CONV_CYC_12B = CONV_TIME_12B_US * 1000 / CLK_PERIOD_NS;
    localparam int SA_PULSE_CYC = SA_PULSE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int NV_WRITE_CYC = NV_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;

    localparam logic [7:0] OP_START_CONV = 8'h51;
    localparam logic [7:0] OP_STOP_CONV = 8'h22;
    localparam logic [7:0] OP_SOFT_RESET = 8'h54;
    localparam logic [7:0] OP_READ_TEMP = 8'haa;
    localparam logic [7:0] OP_READ_UPPER = 8'ha1;
    localparam logic [7:0] OP_READ_LOWER = 8'ha2;
    localparam logic [7:0] OP_WRITE_UPPER = 8'h01;
    localparam logic [7:0] OP_WRITE_LOWER = 8'h02;
    localparam logic [7:0] OP_READ_CONFIG = 8'hac;
    localparam logic [7:0] OP_WRITE_CONFIG = 8'h0c;

    localparam int CMD_BITS = 8;
    localparam int LIMIT_BITS = 12;
    localparam int CONFIG_BITS = 8;

    // conversion_config field positions
    localparam int CFG_DONE = 7;
    localparam int CFG_HIGH_FLAG = 6;
    localparam int CFG_LOW_FLAG = 5;
    localparam int CFG_NV_BUSY = 4;
    localparam int CFG_RES_HI = 3;
    localparam int CFG_RES_LO = 2;
    localparam int CFG_HOST_CTRL = 1;
    localparam int CFG_SINGLE = 0;

    localparam logic RST_RES_HIGH = 1'b1;
    localparam logic RST_RES_LOW = 1'b1;
    localparam logic RST_HOST_CTRL = 1'b0;
    localparam logic RST_SINGLE = 1'b0;
    localparam logic [11:0] RST_UPPER_LIMIT = 12'h000;
    localparam logic [11:0] RST_LOWER_LIMIT = 12'h000;
    localparam logic [11:0] RST_TEMPERATURE = 12'h000;

    // Unused low bits read as zero at coarser resolutions
    function automatic logic [11:0] twt_res_mask(input logic [1:0] res);
        unique case (res)
            2'h0: twt_res_mask = 12'hff8;
            2'h1: twt_res_mask = 12'hffc;
            2'h2: twt_res_mask = 12'hffe;
            2'h3: twt_res_mask = 12'hfff;
        endcase
    endfunction
endpackage

// >>> verilog/twt_conv_if.sv
// Control and status between the command port and the conversion timer.
// Both ends run on mclk; start, stop and last are one-cycle pulses.
`timescale 1ns/10ps
interface twt_conv_if;
    logic start;
    logic stop;
    logic last;
    logic single;
    logic [1:0] res;
    logic busy;
    logic done;

    modport ctrl (output start, output stop, output last, output single,
                  output res, input busy, input done);
    modport engine (input start, input stop, input last, input single,
                    input res, output busy, output done);
endinterface

// >>> verilog/twt_conv_timer.sv
// Conversion timer: times one conversion per resolution and repeats
// unless in single mode. Assumes mclk domain pulses on the interface.
`timescale 1ns/10ps
module twt_conv_timer
#(
    parameter int CNT_W = 28,
    parameter int CYC_9B = twt_pkg::CONV_CYC_9B,
    parameter int CYC_10B = twt_pkg::CONV_CYC_10B,
    parameter int CYC_11B = twt_pkg::CONV_CYC_11B,
    parameter int CYC_12B = twt_pkg::CONV_CYC_12B
)
(
    input wire logic mclk,
    input wire logic nrst,
    twt_conv_if.engine conv
);
    import twt_pkg::*;

    // Counter must hold the longest conversion
    if (CYC_12B > 2 ** CNT_W || CYC_9B < 1)
    begin : g_bad_param
        $error("twt_conv_timer: count parameters out of range");
    end

    typedef enum logic {TWT_IDLE, TWT_RUN} twt_tstate_e;

    twt_tstate_e state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] target;
    logic single_q;
    logic done_q;

    always_comb
    begin
        unique case (conv.res) // R03
            2'h0: target = CNT_W'(CYC_9B - 1);
            2'h1: target = CNT_W'(CYC_10B - 1);
            2'h2: target = CNT_W'(CYC_11B - 1);
            2'h3: target = CNT_W'(CYC_12B - 1);
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst || conv.stop)
        begin
            state <= TWT_IDLE;
            cnt <= '0;
            single_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (conv.start)
        begin
            state <= TWT_RUN;
            cnt <= '0;
            single_q <= conv.single;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (conv.last)
                single_q <= 1'b1;
            if (state == TWT_RUN)
            begin
                if (cnt >= target)
                begin
                    done_q <= 1'b1;
                    cnt <= '0;
                    if (single_q || conv.last)
                        state <= TWT_IDLE; // R01
                end
                else
                    cnt <= cnt + 1'b1; // R02
            end
        end
    end

    assign conv.busy = (state == TWT_RUN);
    assign conv.done = done_q;
endmodule // twt_conv_timer

// >>> verilog/twt_cmd_port.sv
// Three-wire command port of a thermometer: decodes commands, holds the
// limit and configuration registers and steers the conversion timer.
// Assumes select, clock, data and convert pins are asynchronous to mclk,
// with the link clock far slower than mclk.
`timescale 1ns/10ps
module twt_cmd_port
#(
    parameter int CONV_CYC_9B_P = twt_pkg::CONV_CYC_9B,
    parameter int CONV_CYC_10B_P = twt_pkg::CONV_CYC_10B,
    parameter int CONV_CYC_11B_P = twt_pkg::CONV_CYC_11B,
    parameter int CONV_CYC_12B_P = twt_pkg::CONV_CYC_12B,
    parameter int SA_PULSE_CYC_P = twt_pkg::SA_PULSE_CYC,
    parameter int NV_WRITE_CYC_P = twt_pkg::NV_WRITE_CYC
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic xfer_select,
    input wire logic clock_or_convert_n,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe,
    input wire logic [11:0] temp_sample,
    output logic [11:0] temperature,
    output logic converting
);
    import twt_pkg::*;

    localparam int CNT_W = 28;
    localparam int SA_W = 24;

    generate
        if (CONV_CYC_12B_P >= 2 ** CNT_W || CONV_CYC_9B_P < 1 ||
            SA_PULSE_CYC_P >= 2 ** SA_W || SA_PULSE_CYC_P < 1 ||
            NV_WRITE_CYC_P >= 2 ** SA_W || NV_WRITE_CYC_P < 1)
        begin : g_bad_param
            $error("twt_cmd_port: timing parameter out of range");
        end
    endgenerate

    typedef enum logic [1:0] {PH_CMD, PH_WRITE, PH_READ, PH_DONE} twt_phase_e;

    twt_conv_if conv ();

    twt_conv_timer #(
        .CNT_W(CNT_W),
        .CYC_9B(CONV_CYC_9B_P),
        .CYC_10B(CONV_CYC_10B_P),
        .CYC_11B(CONV_CYC_11B_P),
        .CYC_12B(CONV_CYC_12B_P)
    ) u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .conv(conv)
    );

    logic sel_s1, sel_s2, sel_q;
    logic clk_s1, clk_s2, clk_q;
    logic dq_s1, dq_s2;
    logic cnv_s1, cnv_s2, cnv_q;

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            sel_q <= 1'b0;
            clk_s1 <= 1'b1;
            clk_s2 <= 1'b1;
            clk_q <= 1'b1;
            dq_s1 <= 1'b0;
            dq_s2 <= 1'b0;
            cnv_s1 <= 1'b1;
            cnv_s2 <= 1'b1;
            cnv_q <= 1'b1;
        end
        else
        begin
            sel_s1 <= xfer_select;
            sel_s2 <= sel_s1;
            sel_q <= sel_s2;
            clk_s1 <= clock_or_convert_n;
            clk_s2 <= clk_s1;
            clk_q <= clk_s2;
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            cnv_s1 <= clock_or_convert_n;
            cnv_s2 <= cnv_s1;
            cnv_q <= cnv_s2;
        end
    end

    logic clk_rise, clk_fall, sel_rise;
    assign clk_rise = sel_s2 & clk_s2 & ~clk_q; // R04 R08
    assign clk_fall = sel_s2 & ~clk_s2 & clk_q;
    assign sel_rise = sel_s2 & ~sel_q;

    twt_phase_e phase;
    logic [4:0] bit_cnt;
    logic [7:0] cmd_sh;
    logic [7:0] op;
    logic [11:0] wr_sh;
    logic [15:0] rd_sh;
    logic [7:0] next_cmd;
    logic [11:0] next_wr;
    logic cmd_done, wr_last, sw_por;
    logic [4:0] wr_need;

    // Conversion_config storage
    logic cfg_high_flag, cfg_low_flag;
    logic cfg_res_high, cfg_res_low, cfg_host_ctrl, cfg_single;
    logic [11:0] upper_limit, lower_limit;
    logic [23:0] nv_cnt;
    logic [7:0] cfg_read;
    logic [11:0] mask;

    assign next_cmd = {dq_s2, cmd_sh[7:1]}; // R07
    assign next_wr = {dq_s2, wr_sh[11:1]};
    assign cmd_done = clk_rise && phase == PH_CMD &&
                      bit_cnt == 5'(CMD_BITS - 1); // R25
    assign sw_por = cmd_done && next_cmd == OP_SOFT_RESET; // R15 R20
    assign wr_need = (op == OP_WRITE_CONFIG) ? 5'(CONFIG_BITS)
                                             : 5'(LIMIT_BITS);
    assign wr_last = clk_rise && phase == PH_WRITE &&
                     bit_cnt == wr_need - 5'h01; // R13
    assign mask = twt_res_mask({cfg_res_high, cfg_res_low});
    assign cfg_read = {~conv.busy, cfg_high_flag, cfg_low_flag,
                       nv_cnt != '0, cfg_res_high, cfg_res_low,
                       cfg_host_ctrl, cfg_single};

    // Command and data framing
    always_ff @(posedge mclk)
    begin
        if (!nrst || !sel_s2)
        begin
            phase <= PH_CMD; // R05 R25
            bit_cnt <= '0;
            cmd_sh <= '0;
            op <= '0;
            wr_sh <= '0;
        end
        else if (clk_rise)
        begin
            unique case (phase)
                PH_CMD:
                begin
                    cmd_sh <= next_cmd;
                    bit_cnt <= bit_cnt + 5'h01;
                    if (cmd_done)
                    begin
                        op <= next_cmd;
                        bit_cnt <= '0;
                        unique case (next_cmd)
                            OP_WRITE_UPPER, OP_WRITE_LOWER, OP_WRITE_CONFIG:
                                phase <= PH_WRITE; // R11
                            OP_READ_TEMP, OP_READ_UPPER, OP_READ_LOWER,
                            OP_READ_CONFIG:
                                phase <= PH_READ;
                            default:
                                phase <= PH_DONE; // R10
                        endcase
                    end
                end
                PH_WRITE:
                begin
                    wr_sh <= next_wr; // R08
                    bit_cnt <= bit_cnt + 5'h01;
                    if (wr_last)
                        phase <= PH_DONE; // R12
                end
                PH_READ, PH_DONE:
                    bit_cnt <= bit_cnt;
            endcase
        end
    end

    // Read shifter and data pin
    always_ff @(posedge mclk)
    begin
        if (!nrst || !sel_s2)
        begin
            rd_sh <= '0;
            dq_out <= 1'b0;
            dq_oe <= 1'b0; // R05
        end
        else if (cmd_done)
        begin
            unique case (next_cmd) // R16 R17
                OP_READ_TEMP: rd_sh <= {4'h0, temperature}; // R21
                OP_READ_UPPER: rd_sh <= {4'h0, upper_limit};
                OP_READ_LOWER: rd_sh <= {4'h0, lower_limit};
                OP_READ_CONFIG: rd_sh <= {8'h00, cfg_read};
                default: rd_sh <= '0;
            endcase
        end
        else if (clk_fall && phase == PH_READ)
        begin
            dq_out <= rd_sh[0]; // R07 R14
            rd_sh <= {1'b0, rd_sh[15:1]};
            dq_oe <= 1'b1; // R09
        end
        else if (clk_rise)
            dq_oe <= 1'b0; // R09
    end

    // Limit and configuration registers
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            cfg_res_high <= RST_RES_HIGH;
            cfg_res_low <= RST_RES_LOW;
            cfg_host_ctrl <= RST_HOST_CTRL;
            cfg_single <= RST_SINGLE;
            upper_limit <= RST_UPPER_LIMIT;
            lower_limit <= RST_LOWER_LIMIT;
        end
        else if (wr_last)
        begin
            unique case (op)
                OP_WRITE_UPPER: upper_limit <= next_wr & mask; // R18
                OP_WRITE_LOWER: lower_limit <= next_wr & mask; // R18
                OP_WRITE_CONFIG:
                begin
                    cfg_res_high <= next_wr[4 + CFG_RES_HI]; // R17
                    cfg_res_low <= next_wr[4 + CFG_RES_LO];
                    cfg_host_ctrl <= next_wr[4 + CFG_HOST_CTRL];
                    cfg_single <= next_wr[4 + CFG_SINGLE];
                end
                default: upper_limit <= upper_limit;
            endcase
        end
    end

    // Volatile flags and the nonvolatile busy window
    always_ff @(posedge mclk)
    begin
        if (!nrst || sw_por)
        begin
            cfg_high_flag <= 1'b0; // R20
            cfg_low_flag <= 1'b0;
            nv_cnt <= '0;
        end
        else if (wr_last)
        begin
            if (op == OP_WRITE_CONFIG)
            begin
                cfg_high_flag <= next_wr[4 + CFG_HIGH_FLAG];
                cfg_low_flag <= next_wr[4 + CFG_LOW_FLAG];
            end
            nv_cnt <= 24'(NV_WRITE_CYC_P); // R22
        end
        else if (nv_cnt != '0)
            nv_cnt <= nv_cnt - 24'h000001;
    end

    // Result register
    always_ff @(posedge mclk)
    begin
        if (!nrst || sw_por)
            temperature <= RST_TEMPERATURE; // R20
        else if (conv.done)
            temperature <= temp_sample & mask; // R03 R21
    end

    // Stand-alone convert pin tracking
    logic sa_en, sa_run;
    logic [23:0] sa_cnt;
    assign sa_en = ~cfg_host_ctrl & ~sel_s2; // R23

    always_ff @(posedge mclk)
    begin
        if (!nrst || sw_por || sel_rise)
        begin
            sa_run <= 1'b0;
            sa_cnt <= '0;
        end
        else if (sa_en && !cnv_s2 && cnv_q)
        begin
            sa_run <= 1'b1; // R24
            sa_cnt <= '0;
        end
        else if (sa_run && cnv_s2)
            sa_run <= 1'b0;
        else if (sa_run && sa_cnt != 24'(SA_PULSE_CYC_P))
            sa_cnt <= sa_cnt + 24'h000001;
    end

    // Conversion requests
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            conv.start <= 1'b0;
            conv.stop <= 1'b0;
            conv.last <= 1'b0;
            conv.single <= 1'b0;
        end
        else
        begin
            conv.start <= 1'b0;
            conv.stop <= 1'b0;
            conv.last <= 1'b0;
            if (sw_por)
                conv.stop <= 1'b1; // R20
            else if (cmd_done && next_cmd == OP_START_CONV)
            begin
                conv.start <= 1'b1; // R15
                conv.single <= cfg_single; // R01 R02
            end
            else if (cmd_done && next_cmd == OP_STOP_CONV && !conv.single)
                conv.stop <= 1'b1; // R19
            else if (sel_rise && sa_run)
                conv.stop <= 1'b1; // R23
            else if (sa_en && !cnv_s2 && cnv_q)
            begin
                conv.start <= 1'b1; // R24
                conv.single <= 1'b0;
            end
            else if (sa_run && cnv_s2)
            begin
                if (sa_cnt < 24'(SA_PULSE_CYC_P))
                    conv.last <= 1'b1; // R24
                else
                    conv.stop <= 1'b1; // R24
            end
        end
    end

    assign conv.res = {cfg_res_high, cfg_res_low}; // R03

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            converting <= 1'b0;
        else
            converting <= conv.busy;
    end
endmodule // twt_cmd_port

// >>> sim/twt_cmd_port_assertions.sv
// Concurrent checks on the ports of the three-wire command port.
// Assumes a link clock much slower than mclk, as in the bench.
`timescale 1ns/10ps
module twt_cmd_port_assertions
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic xfer_select,
    input wire logic clock_or_convert_n,
    input wire logic dq_in,
    input wire logic dq_out,
    input wire logic dq_oe,
    input wire logic [11:0] temp_sample,
    input wire logic [11:0] temperature,
    input wire logic converting
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sel_fall_float_a: assert property ($fell(xfer_select) |-> ##[0:4] !dq_oe)
        else $error("data line still driven after deselect");
    idle_float_a: assert property ((!xfer_select)[*5] |-> !dq_oe)
        else $error("data line driven while deselected");
    drive_on_fall_a: assert property ($rose(dq_oe) |->
        !$past(clock_or_convert_n, 2) && $past(xfer_select, 3))
        else $error("data driven without a falling link clock");
    float_on_rise_a: assert property ($fell(dq_oe) && xfer_select |->
        $past(clock_or_convert_n, 2))
        else $error("data released before the rising link clock");
    bit_hold_a: assert property (dq_oe && $rose(clock_or_convert_n) |=>
        dq_oe && $stable(dq_out))
        else $error("read bit not held through the rising edge");
    bit_stable_a: assert property (dq_oe && $past(dq_oe) |-> $stable(dq_out))
        else $error("read bit changed while driven");
    temp_update_a: assert property ($changed(temperature) |->
        temperature == 12'h000 || $past(converting))
        else $error("temperature changed without a conversion");
    temp_masked_a: assert property ($changed(temperature) |->
        (temperature & ~temp_sample) == 12'h000)
        else $error("temperature holds bits absent from the sample");
    conv_cause_a: assert property ($rose(converting) |->
        $past(xfer_select, 3) || !$past(clock_or_convert_n, 3))
        else $error("conversion started without a command or request");

    read_bit_c: cover property ($rose(dq_oe));
    conv_start_c: cover property ($rose(converting));
    conv_end_c: cover property ($fell(converting));
    temp_new_c: cover property ($changed(temperature));
endmodule // twt_cmd_port_assertions

bind twt_cmd_port twt_cmd_port_assertions u_twt_cmd_port_assertions
(
    .mclk(mclk),
    .nrst(nrst),
    .xfer_select(xfer_select),
    .clock_or_convert_n(clock_or_convert_n),
    .dq_in(dq_in),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .temp_sample(temp_sample),
    .temperature(temperature),
    .converting(converting)
);

// >>> sim/twt_host_model.sv
// Host side of the three-wire link: select, link clock and data.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/10ps
module twt_host_model
#(
    parameter int HALF = 8,
    parameter int NV_WAIT = 40
)
(
    input wire logic mclk,
    input wire logic dq_wire,
    output logic xfer_select,
    output logic clock_or_convert_n,
    output logic host_d,
    output logic host_oe
);
    logic [15:0] rd_data;
    event got;

    initial
    begin
        xfer_select = 1'b0;
        clock_or_convert_n = 1'b1;
        host_d = 1'b0;
        host_oe = 1'b0;
        rd_data = 16'h0000;
    end

    // Half a link clock period, ending just after an mclk edge
    task automatic half();
        repeat (HALF) @(posedge mclk);
        #1;
    endtask

    task automatic xact(input logic [7:0] cmd, input int nwr,
                        input logic [15:0] wd, input int nrd);
        logic [23:0] sh;
        sh = {wd, cmd};
        half();
        xfer_select = 1'b1;
        half();
        for (int i = 0; i < 8 + nwr; i++)
        begin
            clock_or_convert_n = 1'b0;
            host_oe = 1'b1;
            host_d = sh[i];
            half();
            clock_or_convert_n = 1'b1;
            half();
        end
        host_oe = 1'b0;
        for (int i = 0; i < nrd; i++)
        begin
            clock_or_convert_n = 1'b0;
            half();
            rd_data[i] = dq_wire;
            clock_or_convert_n = 1'b1;
            half();
        end
        xfer_select = 1'b0;
        if (nrd > 0)
            -> got;
        if (nwr > 0)
            repeat (NV_WAIT) @(posedge mclk);
    endtask

    // Stand-alone convert request level while deselected
    task automatic set_cnv(input logic v);
        @(posedge mclk);
        #1;
        clock_or_convert_n = v;
    endtask
endmodule // twt_host_model

// >>> sim/twt_cmd_port_tb_top.sv
// Self-checking bench of the three-wire command port with a host model.
// Assumes short conversion and write counts set through parameters.
`timescale 1ns/10ps
module twt_cmd_port_tb_top;
    import twt_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] temp_sample = 12'h000;
    logic [11:0] lim;
    logic xfer_select, clock_or_convert_n, host_d, host_oe;
    logic dq_out, dq_oe, converting;
    logic [11:0] temperature;
    wire dq_wire = dq_oe ? dq_out : (host_oe ? host_d : 1'b1);
    int fail_count = 0;
    int checks = 0;
    logic [15:0] exp_q[$];

    always #2.5 mclk = ~mclk;

    // Short conversion, pulse and write counts keep the run brief
    localparam int TB_CONV = 20;
    localparam int TB_SA = 50;
    localparam int TB_NV = 30;

    twt_cmd_port #(.CONV_CYC_9B_P(TB_CONV), .CONV_CYC_10B_P(2 * TB_CONV),
        .CONV_CYC_11B_P(4 * TB_CONV), .CONV_CYC_12B_P(8 * TB_CONV),
        .SA_PULSE_CYC_P(TB_SA), .NV_WRITE_CYC_P(TB_NV)) u_twt_cmd_port
    (
        .mclk(mclk),
        .nrst(nrst),
        .xfer_select(xfer_select),
        .clock_or_convert_n(clock_or_convert_n),
        .dq_in(dq_wire),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .temp_sample(temp_sample),
        .temperature(temperature),
        .converting(converting)
    );

    twt_host_model #(.NV_WAIT(TB_NV + 10)) u_twt_host_model
    (
        .mclk(mclk),
        .dq_wire(dq_wire),
        .xfer_select(xfer_select),
        .clock_or_convert_n(clock_or_convert_n),
        .host_d(host_d),
        .host_oe(host_oe)
    );

    task automatic finish_test();
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp_bit(input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic rd(input logic [7:0] op, input logic [15:0] e);
        exp_q.push_back(e);
        u_twt_host_model.xact(op, 0, 16'h0000, 16);
    endtask

    task automatic cmd(input logic [7:0] op, input int n, input logic [15:0] d);
        u_twt_host_model.xact(op, n, d, 0);
    endtask

    task automatic wait_conv(input logic v, input int lim_cyc);
        int n;
        n = 0;
        while (converting !== v && n < lim_cyc)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        cmp_bit(v, converting);
        if (converting !== v)
            finish_test();
    endtask

    // Each returned read word is matched against the oldest expectation
    initial
    begin
        forever
        begin
            @(u_twt_host_model.got);
            if (exp_q.size() == 0)
                cmp_word(16'hdead, u_twt_host_model.rd_data);
            else
                cmp_word(exp_q.pop_front(), u_twt_host_model.rd_data);
        end
    end

    initial
    begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        finish_test();
    end

    initial
    begin
        void'($urandom(33920));
        repeat (10) @(posedge mclk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        temp_sample = 12'($urandom);
        lim = 12'($urandom);
        rd(OP_READ_CONFIG, 16'h008c);
        cmd(OP_WRITE_UPPER, 16, {4'ha, lim});
        rd(OP_READ_UPPER, {4'h0, lim});
        cmd(OP_WRITE_LOWER, 11, {5'h1f, ~lim[10:0]});
        rd(OP_READ_LOWER, 16'h0000);
        rd(8'hff, 16'hffff);
        cmd(OP_WRITE_CONFIG, 8, 16'h0003);
        rd(OP_READ_CONFIG, 16'h0083);
        cmd(OP_WRITE_LOWER, 12, {4'h0, lim});
        rd(OP_READ_LOWER, {4'h0, lim & 12'hff8});
        cmd(OP_WRITE_CONFIG, 8, 16'h000f);
        cmd(OP_START_CONV, 0, 16'h0000);
        wait_conv(1'b1, 20);
        wait_conv(1'b0, 200);
        repeat (300) @(posedge mclk);
        #1;
        cmp_bit(1'b0, converting);
        cmp_word({4'h0, temp_sample}, {4'h0, temperature});
        rd(OP_READ_TEMP, {4'h0, temp_sample});
        cmd(OP_WRITE_CONFIG, 8, 16'h000e);
        #1;
        temp_sample = 12'($urandom);
        cmd(OP_START_CONV, 0, 16'h0000);
        wait_conv(1'b1, 20);
        repeat (500) @(posedge mclk);
        #1;
        cmp_bit(1'b1, converting);
        cmd(OP_STOP_CONV, 0, 16'h0000);
        wait_conv(1'b0, 20);
        rd(OP_READ_TEMP, {4'h0, temp_sample});
        cmd(OP_START_CONV, 0, 16'h0000);
        wait_conv(1'b1, 20);
        cmd(OP_SOFT_RESET, 0, 16'h0000);
        wait_conv(1'b0, 20);
        rd(OP_READ_TEMP, 16'h0000);
        rd(OP_READ_UPPER, {4'h0, lim});
        rd(OP_READ_CONFIG, 16'h008e);
        u_twt_host_model.set_cnv(1'b0);
        repeat (50) @(posedge mclk);
        #1;
        cmp_bit(1'b0, converting);
        u_twt_host_model.set_cnv(1'b1);
        cmd(OP_WRITE_CONFIG, 8, 16'h000c);
        u_twt_host_model.set_cnv(1'b0);
        wait_conv(1'b1, 20);
        repeat (400) @(posedge mclk);
        #1;
        cmp_bit(1'b1, converting);
        u_twt_host_model.set_cnv(1'b1);
        wait_conv(1'b0, 20);
        u_twt_host_model.set_cnv(1'b0);
        repeat (10) @(posedge mclk);
        u_twt_host_model.set_cnv(1'b1);
        wait_conv(1'b1, 20);
        wait_conv(1'b0, 200);
        repeat (300) @(posedge mclk);
        #1;
        cmp_bit(1'b0, converting);
        cmp_word(16'h0000, 16'(exp_q.size()));
        finish_test();
    end
endmodule // twt_cmd_port_tb_top
